/* design/divctl_pkg.sv */
// Constants shared by the dual-modulus divider control block
package divctl_pkg;
  // Swallow count width covers A up to 127, enough for a 128/129 prescaler
  localparam int SWALLOW_W_DEF = 7;
  // Main count width default
  localparam int MAIN_W_DEF = 10;
  // Smallest and largest supported lower prescaler ratio
  localparam int P_MIN = 3;
  localparam int P_MAX = 128;
  // Reset values and synchroniser depth
  localparam logic MOD_SEL_RST = 1'h1;
  localparam logic PULSE_RST = 1'h0;
  localparam int SYNC_STAGES = 3;
endpackage : divctl_pkg

/* design/fin_edge_sync.sv */
// Three-stage synchroniser and rising-edge detector for the prescaler input
`timescale 1ns/1ns
`default_nettype none
module fin_edge_sync (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // Synchroniser chain; the first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s1_q <= 1'h0;
      s2_q <= 1'h0;
      s3_q <= 1'h0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered level only moves once the second and third stages agree
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      level_q <= 1'h0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  // One-cycle pulse on each accepted low-to-high change
  assign rise = (s2_q == s3_q) && s3_q && !level_q;
endmodule : fin_edge_sync
`default_nettype wire

/* design/dual_modulus_divider_control.sv */
// Dual-modulus feedback divider: main and swallow counters driving modulus select
`timescale 1ns/1ns
`default_nettype none
module dual_modulus_divider_control import divctl_pkg::*; #(
  parameter int MAIN_W = MAIN_W_DEF,
  parameter int SWALLOW_W = SWALLOW_W_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic prescaler_in,
  input wire logic [MAIN_W-1:0] main_count,
  input wire logic [SWALLOW_W-1:0] swallow_count,
  output logic modulus_select_out,
  output logic feedback_pulse_out
);
  logic fin_rise;
  logic reload;
  logic [MAIN_W-1:0] n_rem_q;
  logic [MAIN_W-1:0] n_rem_d;
  logic [SWALLOW_W-1:0] a_rem_q;
  logic [SWALLOW_W-1:0] a_rem_d;
  logic [MAIN_W-1:0] n_lat_q;
  logic [SWALLOW_W-1:0] a_lat_q;

  // Prescaler output arrives from another domain, so it is resynchronised
  // one edge per group
  fin_edge_sync u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(prescaler_in),
    .rise(fin_rise)
  );

  // Next-count logic; counts only change on an accepted prescaler edge
  always_comb begin
    n_rem_d = n_rem_q;
    a_rem_d = a_rem_q;
    reload = 1'h0;
    if (fin_rise) begin
      if (n_rem_q <= MAIN_W'(1)) begin
        reload = 1'h1;
        n_rem_d = main_count;
        a_rem_d = swallow_count;
      end else begin
        n_rem_d = n_rem_q - MAIN_W'(1);
        a_rem_d = (a_rem_q != '0) ? a_rem_q - SWALLOW_W'(1) : '0;
      end
    end
  end

  // Remaining-group counters; reset leaves main at zero so the first edge loads
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      n_rem_q <= '0;
      a_rem_q <= '0;
    end else begin
      n_rem_q <= n_rem_d;
      a_rem_q <= a_rem_d;
    end
  end

  // Counts in force for the cycle; inputs may change freely mid-cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      n_lat_q <= '0;
      a_lat_q <= '0;
    end else if (reload) begin
      n_lat_q <= main_count;
      a_lat_q <= swallow_count;
    end
  end

  // Registered from the next count so the prescaler sees the new modulus
  // as soon as the counters step, saving one clock of the setup budget
  // high selects P
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      modulus_select_out <= MOD_SEL_RST;
    end else begin
      modulus_select_out <= (a_rem_d == '0);
    end
  end

  // Feedback pulse to the phase detector, once per full division cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      feedback_pulse_out <= PULSE_RST;
    end else begin
      feedback_pulse_out <= reload;
    end
  end

  // Helper counters: groups in the cycle and groups at P+1
  logic [MAIN_W:0] grp_q;
  logic [MAIN_W:0] low_grp_q;
  logic seen_q;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      grp_q <= '0;
      low_grp_q <= '0;
      seen_q <= 1'h0;
    end else if (fin_rise) begin
      grp_q <= reload ? '0 : grp_q + (MAIN_W+1)'(1);
      low_grp_q <= reload ? '0 : low_grp_q + (MAIN_W+1)'(!modulus_select_out);
      seen_q <= seen_q | reload;
    end
  end

  property p_cycle_groups;
    @(posedge core_clk) disable iff (!rst_b)
      (fin_rise && reload && seen_q && n_lat_q != '0) |-> (grp_q + (MAIN_W+1)'(1) == (MAIN_W+1)'(n_lat_q));
  endproperty
  a_cycle_groups: assert property (p_cycle_groups) else $error("division cycle group count wrong");

  property p_low_groups;
    @(posedge core_clk) disable iff (!rst_b)
      (fin_rise && reload && seen_q && n_lat_q >= MAIN_W'(a_lat_q) && n_lat_q != '0)
        |-> (low_grp_q + (MAIN_W+1)'(!modulus_select_out) == (MAIN_W+1)'(a_lat_q));
  endproperty
  a_low_groups: assert property (p_low_groups) else $error("P+1 group count wrong");

  property p_select_polarity;
    @(posedge core_clk) disable iff (!rst_b)
      modulus_select_out == (a_rem_q == '0);
  endproperty
  a_select_polarity: assert property (p_select_polarity) else $error("modulus select polarity wrong");

  property p_reload_low;
    @(posedge core_clk) disable iff (!rst_b)
      (fin_rise && reload && swallow_count != '0) |=> (!modulus_select_out && feedback_pulse_out);
  endproperty
  a_reload_low: assert property (p_reload_low) else $error("select not low after reload");

  property p_step;
    @(posedge core_clk) disable iff (!rst_b)
      (fin_rise && !reload) |=> (n_rem_q == $past(n_rem_q) - MAIN_W'(1));
  endproperty
  a_step: assert property (p_step) else $error("main count did not step");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_b)
      !fin_rise |=> ($stable(n_rem_q) && $stable(a_rem_q) && !feedback_pulse_out);
  endproperty
  a_hold: assert property (p_hold) else $error("counts moved without an edge");

  property p_swallow_load;
    @(posedge core_clk) disable iff (!rst_b)
      (fin_rise && reload) |=> (a_rem_q == $past(swallow_count) && n_lat_q == $past(main_count));
  endproperty
  a_swallow_load: assert property (p_swallow_load) else $error("counts not loaded");

  property p_pulse_single;
    @(posedge core_clk) disable iff (!rst_b)
      feedback_pulse_out |=> !feedback_pulse_out;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("feedback pulse too long");

  // reset selects P
  // Select parks high in reset so a live prescaler divides by the lower ratio
  property p_reset_state;
    @(posedge core_clk)
      !rst_b |=> (modulus_select_out == MOD_SEL_RST && feedback_pulse_out == PULSE_RST);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("outputs not at reset values");

  property p_no_swallow_high;
    @(posedge core_clk) disable iff (!rst_b)
      (fin_rise && reload && swallow_count == '0) |=> (modulus_select_out && feedback_pulse_out);
  endproperty
  a_no_swallow_high: assert property (p_no_swallow_high) else $error("select low with zero swallow");

  property p_swallow_step;
    @(posedge core_clk) disable iff (!rst_b)
      (fin_rise && !reload && a_rem_q != '0) |=> (a_rem_q == $past(a_rem_q) - SWALLOW_W'(1));
  endproperty
  a_swallow_step: assert property (p_swallow_step) else $error("swallow count did not step");

  property p_select_low_swallow;
    @(posedge core_clk) disable iff (!rst_b)
      (fin_rise && !reload && a_rem_q > SWALLOW_W'(1)) |=> !modulus_select_out;
  endproperty
  a_select_low_swallow: assert property (p_select_low_swallow) else $error("select rose early");

  // P after swallow
  // Once the swallow count is spent the rest of the cycle must stay at P
  property p_swallow_floor;
    @(posedge core_clk) disable iff (!rst_b)
      (fin_rise && !reload && a_rem_q == '0) |=> (a_rem_q == '0 && modulus_select_out);
  endproperty
  a_swallow_floor: assert property (p_swallow_floor) else $error("select fell after swallow done");

  // counts held mid-cycle
  // Latched counts only move at reload, so reprogramming never splits a cycle
  property p_latch_hold;
    @(posedge core_clk) disable iff (!rst_b)
      !reload |=> ($stable(n_lat_q) && $stable(a_lat_q));
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched counts moved mid-cycle");

  // Main scenarios
  c_reload_swallow: cover property (@(posedge core_clk) disable iff (!rst_b)
    fin_rise && reload && swallow_count != '0);
  c_reload_no_swallow: cover property (@(posedge core_clk) disable iff (!rst_b)
    fin_rise && reload && swallow_count == '0);
  c_select_rise: cover property (@(posedge core_clk) disable iff (!rst_b)
    !modulus_select_out ##1 modulus_select_out);
  c_equal_counts: cover property (@(posedge core_clk) disable iff (!rst_b)
    fin_rise && reload && main_count == MAIN_W'(swallow_count));
  c_swallow_done: cover property (@(posedge core_clk) disable iff (!rst_b)
    fin_rise && !reload && a_rem_q == SWALLOW_W'(1));
endmodule : dual_modulus_divider_control
`default_nettype wire

/* tb/prescaler_model.sv */
// Behavioural dual-modulus prescaler fed by the oscillator
`timescale 1ns/1ns
`default_nettype none
module prescaler_model (
  input wire logic osc_clk,
  input wire logic [7:0] lower_ratio,
  input wire logic modulus_select,
  output logic pre_out
);
  int cnt = 0;
  // select sets ratio
  // Ratio is judged on the last input cycle, since real parts latch select late;
  // the lower ratio is a live input so one bench can walk several prescaler pairs
  always @(posedge osc_clk) begin
    if (cnt >= ((modulus_select === 1'h0) ? int'(lower_ratio) : int'(lower_ratio) - 1)) cnt <= 0;
    else cnt <= cnt + 1;
  end
  assign pre_out = (cnt == 0);
endmodule : prescaler_model
`default_nettype wire

/* tb/dual_modulus_divider_control_tb.sv */
// Self-checking bench for the dual-modulus divider control
`timescale 1ns/1ns
`default_nettype none
module dual_modulus_divider_control_tb;
  import divctl_pkg::*;
  int p_ratio = 3;
  logic core_clk = 1'h0;
  logic rst_b = 1'h0;
  logic osc_clk = 1'h0;
  logic pre;
  logic [9:0] main_count = 10'h000;
  logic [6:0] swallow_count = 7'h00;
  logic mod_sel;
  logic fb_pulse;
  int fail_count = 0;
  int n_checks = 0;
  always #20 core_clk = ~core_clk;
  // input rate limit
  // Oscillator at four core periods keeps each prescaler high phase past the sync depth
  always #80 osc_clk = ~osc_clk;
  dual_modulus_divider_control #(.MAIN_W(10), .SWALLOW_W(7)) u_dual_modulus_divider_control (
    .core_clk(core_clk), .rst_b(rst_b), .prescaler_in(pre), .main_count(main_count),
    .swallow_count(swallow_count), .modulus_select_out(mod_sel), .feedback_pulse_out(fb_pulse));
  prescaler_model u_prescaler_model (.osc_clk(osc_clk), .lower_ratio(p_ratio[7:0]), .modulus_select(mod_sel),
    .pre_out(pre));
  task automatic results();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic check_int(input string what, input int exp, input int got);
    n_checks++;
    if (exp !== got) begin
      fail_count++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_int
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (exp !== got) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  // Core cycles up to the next feedback pulse, and how many of them had select low
  task automatic measure(output int cyc, output int low);
    cyc = 0;
    low = 0;
    do begin
      @(posedge core_clk);
      #1;
      cyc++;
      if (mod_sel === 1'h0) low++;
      if (cyc > 5000) begin
        fail_count++;
        $display("ERROR feedback pulse expected by 5000 seen none");
        results();
      end
    end while (fb_pulse !== 1'h1);
  endtask : measure
  // New counts take effect at the reload that raises the first pulse after programming
  task automatic run_ratio(input int n, input int a);
    int cyc;
    int low;
    @(negedge core_clk);
    main_count = n[9:0];
    swallow_count = a[6:0];
    measure(cyc, low);
    measure(cyc, low);
    check_int("division period", (n * p_ratio + a) * 4, cyc);
    check_int("select low time", a * (p_ratio + 1) * 4, low);
  endtask : run_ratio
  task automatic scen_reset();
    check_bit("select in reset", MOD_SEL_RST, mod_sel);
    check_bit("pulse in reset", PULSE_RST, fb_pulse);
  endtask : scen_reset
  // Swallow stepped 0..P-1 at minimum main count, then main count bumped
  task automatic scen_sweep();
    for (int a = 0; a < p_ratio; a++) run_ratio(p_ratio - 1, a);
    run_ratio(p_ratio, 0);
    run_ratio(6, 1);
  endtask : scen_sweep
  // Counts changed just after a reload must not disturb the running period
  task automatic scen_mid_change();
    int cyc;
    int low;
    run_ratio(5, 1);
    @(negedge core_clk);
    main_count = 10'h002;
    swallow_count = 7'h00;
    measure(cyc, low);
    check_int("period before reload", 64, cyc);
    measure(cyc, low);
    check_int("period after reload", 24, cyc);
    check_int("select low at A zero", 0, low);
  endtask : scen_mid_change
  task automatic scen_wide();
    @(negedge core_clk);
    p_ratio = 128;
    run_ratio(3, 2);
  endtask : scen_wide
  // binary code load: low three bits to swallow, the rest to main, for P of 8
  task automatic scen_binary();
    int cyc;
    int low;
    int code;
    code = 77;
    @(negedge core_clk);
    p_ratio = 8;
    swallow_count = {4'h0, code[2:0]};
    main_count = code[12:3];
    measure(cyc, low);
    measure(cyc, low);
    check_int("binary total period", code * 4, cyc);
    check_int("binary select low time", code[2:0] * 9 * 4, low);
  endtask : scen_binary
  initial begin
    repeat (10) @(negedge core_clk);
    scen_reset();
    rst_b = 1'h1;
    scen_sweep();
    scen_mid_change();
    scen_wide();
    scen_binary();
    results();
  end
endmodule : dual_modulus_divider_control_tb
`default_nettype wire
